// >>> design/ssr_regs.sv
// Status, identification and byte-port registers behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
// Notes on behaviour
// - Target outbound phases: complete on last byte in
// - Otherwise bus complete equals transfer done
// - Transfer done on end count, last out
// - System parity flag; cleared by status read
// - Bit 6 shows bus reset live
// - Bit 7 shows attention live
// - Phase/condition register read at 0DH
// - Bits 2..0 mirror MSG, C/D, I/O
// - Persistent bus-free after four clocks
// - Windowed bus-free: five clocks, three hold
// - Halted only initiator; cleared by read
// - Bus free phase latched; read clears
// - Write 0DH stores target id
// - Read 0EH gives selector id, own masked
// - Write 0EH stores own id
// - Read 0FH pops received byte
// - Write 0FH pushes byte to transmit
// - Transfer/parity status read-only at 0CH
module ssr_regs
	import ssr_pkg::*;
(
	// Clock, reset and the register bus
	input  wire logic       mclk,          // 100 MHz clock
	input  wire logic       reset_n,       // Sync reset, low
	input  wire logic [7:0] s_axi_awaddr,  // Write address
	input  wire logic       s_axi_awvalid, // Write address valid
	output logic            s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,  // Write data
	input  wire logic [3:0] s_axi_wstrb,   // Write strobes
	input  wire logic       s_axi_wvalid,  // Write data valid
	output logic            s_axi_wready,  // Write data ready
	output logic [1:0]      s_axi_bresp,   // Write response
	output logic            s_axi_bvalid,  // Write response valid
	input  wire logic       s_axi_bready,  // Write response ready
	input  wire logic [7:0] s_axi_araddr,  // Read address
	input  wire logic       s_axi_arvalid, // Read address valid
	output logic            s_axi_arready, // Read address ready
	output logic [31:0]     s_axi_rdata,   // Read data
	output logic [1:0]      s_axi_rresp,   // Read response
	output logic            s_axi_rvalid,  // Read data valid
	input  wire logic       s_axi_rready,  // Read data ready
	// Bus control lines straight from the pins, asynchronous
	input  wire logic       scsi_bsy,      // Bus BSY, pin
	input  wire logic       scsi_sel,      // Bus SEL, pin
	input  wire logic       scsi_rst,      // Bus RST, pin
	input  wire logic       scsi_atn,      // Bus ATN, pin
	input  wire logic       scsi_msg,      // Bus MSG, pin
	input  wire logic       scsi_cd,       // Bus C/D, pin
	input  wire logic       scsi_io,       // Bus I/O, pin
	input  wire logic       incoming_request_line, // Bus REQ, pin
	// Core signals, already in the mclk domain
	input  wire logic       target_mode,   // Core in target mode
	input  wire logic       end_count,     // Byte counter end count
	input  wire logic       count_zero,    // Byte counter is zero
	input  wire logic       last_in,       // Last byte into buffer, pulse
	input  wire logic       last_out,      // Last byte out of buffer, pulse
	input  wire logic       sys_par_even,  // Even parity on system bus
	input  wire logic       scsi_par_err,  // SCSI data parity error
	input  wire logic       bus_free_phase, // Bus free circuit fires
	input  wire logic [7:0] sel_id_bus,    // Id seen in selection
	input  wire logic       sel_id_stb,    // Latch selection id
	input  wire logic [7:0] rx_byte,       // Head of receive buffer
	// Byte port and stored ids toward the core
	output logic            rx_pop,        // Take one received byte
	output logic [7:0]      tx_byte,       // Byte to transmit
	output logic            tx_push,       // Push transmit byte
	output logic [7:0]      target_id_select, // Stored target id
	output logic [7:0]      own_bus_id,    // Stored own id
	output logic            irq            // Level interrupt
);
	// Whole state of the block: one packed struct, filled by one
	// combinational process and registered by one clocked process,
	// so no field can pick up a second driver
	typedef struct packed {
		// Every pin gets its own two-flop chain; no pin is
		// combined with another before it is clocked twice
		logic [1:0] rs, ss;          // Sync stages: rst, atn
		logic [1:0] bs, ts;          // Sync stages: bsy, sel
		logic [1:0] ps_a, ps_b;      // Phase sync
		logic       ph_a, ph_b;      // Phase msb sync
		logic [1:0] rq;              // Request sync
		logic       rq_d;            // Request delayed
		// Bus-free timing
		logic [2:0] free_cnt;        // Bus-free run length
		logic [2:0] hold_cnt;        // Window hold counter
		logic       free_p;          // Persistent bus-free
		logic       free_w;          // Windowed bus-free
		// Latched and live status bits
		logic       cmpl_in;         // Complete on inbound
		logic       td;              // Transfer done
		logic       sys_parity_err;            // System parity error
		logic       halted;          // Halted
		logic       bfpd;            // Bus free phase detect
		// Stored ids and interrupt state
		logic [7:0] sel_id;          // Latched selector id
		logic [7:0] tgt_id;          // Target id
		logic [7:0] own_id;          // Own id
		logic [3:0] ev;              // Sticky events
		logic [3:0] mask;            // Event mask
		// Register bus channel state
		logic       aw_h, w_h;       // Write channels held
		logic [7:0] aw_a;            // Held write address
		logic [31:0] w_d;            // Held write data
		logic [3:0] w_s;             // Held strobes
		logic       bvalid;          // Write response valid
		logic [1:0] bresp;           // Write response code
		logic       rvalid;          // Read data valid
		logic [31:0] rdata;          // Read data
		logic [1:0] rresp;           // Read response code
		// Byte port toward the core buffer
		logic       rx_pop;          // Pop pulse
		logic       tx_push;         // Push pulse
		logic [7:0] tx_byte;         // Transmit byte
		logic       irq;             // Interrupt output
		logic       stc_d;           // Bus complete, one clock ago
		// Channel readies are flops so every port leaves a register
		logic       awrdy;           // Write address ready
		logic       wrdy;            // Write data ready
		logic       arrdy;           // Read address ready
	} ssr_state_t;

	// Present and next state
	ssr_state_t st, next_st;
	logic [7:0] xfer_stat, phase_stat;   // Assembled views
	logic       bus_xfer_complete;                     // Bus transfer complete
	logic       do_wr, do_rd;            // Access this cycle
	logic       rd_xfer, rd_phase;       // Clearing reads
	logic [7:0] wb;                      // Write byte
	logic       free_now;                // BSY and SEL false, synced

	// Registered outputs: every port below is a field of st, so no
	// input reaches an output of this block without a flop between
	assign s_axi_awready    = st.awrdy;
	assign s_axi_wready     = st.wrdy;
	assign s_axi_bvalid     = st.bvalid;
	assign s_axi_bresp      = st.bresp;
	assign s_axi_arready    = st.arrdy;
	assign s_axi_rvalid     = st.rvalid;
	assign s_axi_rdata      = st.rdata;
	assign s_axi_rresp      = st.rresp;
	assign rx_pop           = st.rx_pop;
	assign tx_push          = st.tx_push;
	assign tx_byte          = st.tx_byte;
	assign target_id_select = st.tgt_id;
	assign own_bus_id       = st.own_id;
	assign irq              = st.irq;

	// Next-state logic for everything; the order of the statements
	// below matters where a clear and a set meet in one cycle, since
	// the later assignment wins
	always_comb begin
		next_st = st;
		// Two-flop synchronisers; first stage read only by second.
		// Phase lines are read as a group and may mix for a clock
		next_st.rs   = {st.rs[0], scsi_rst};
		next_st.ss   = {st.ss[0], scsi_atn};
		next_st.bs   = {st.bs[0], scsi_bsy};
		next_st.ts   = {st.ts[0], scsi_sel};
		// Free only when both synced lines read false; the sync adds
		// two clocks to every bus-free figure below
		free_now     = !st.bs[1] && !st.ts[1];
		next_st.ps_a = {st.ps_a[0], scsi_cd};
		next_st.ps_b = {st.ps_b[0], scsi_io};
		next_st.ph_a = scsi_msg;
		next_st.ph_b = st.ph_a;
		next_st.rq   = {st.rq[0], incoming_request_line};
		next_st.rq_d = st.rq[1];
		// Completion on the way into the buffer counts only in target
		// mode with I/O low (outbound phase); elsewhere it is done
		bus_xfer_complete = st.td;
		if (target_mode && !st.ps_b[1]) bus_xfer_complete = st.cmpl_in;
		next_st.stc_d = bus_xfer_complete;
		// Assemble the two status views; unused bits read as zero
		xfer_stat = 8'h0_000;
		xfer_stat[SSR_B_STC]  = bus_xfer_complete;
		xfer_stat[SSR_B_TD]   = st.td;
		xfer_stat[SSR_B_SYS_PARITY_ERR] = st.sys_parity_err;
		xfer_stat[SSR_B_RST]  = st.rs[1];
		xfer_stat[SSR_B_ATN]  = st.ss[1];
		phase_stat = 8'h0_000;
		phase_stat[2:0] = {st.ph_b, st.ps_a[1], st.ps_b[1]};
		phase_stat[SSR_B_FREE_P] = st.free_p;
		phase_stat[SSR_B_FREE_W] = st.free_w;
		phase_stat[SSR_B_HALT]   = st.halted;
		phase_stat[SSR_B_BFPD]   = st.bfpd;
		// Bus-free run counter saturates at window count, so a long
		// idle bus never wraps it back below the thresholds
		if (!free_now) begin
			next_st.free_cnt = 3'h0_000;
		end else if (st.free_cnt != SSR_FREE_W_CNT) begin
			next_st.free_cnt = st.free_cnt + 3'h0_001;
		end
		// Persistent flag follows free run directly and drops on the
		// first clock the synced lines show a busy bus
		next_st.free_p = free_now &&
			(st.free_cnt >= SSR_FREE_P_CNT);
		// Windowed flag lingers after bus busy: the hold counter is
		// reloaded each free clock once the run reaches window count and
		// counts down once the bus is taken, so the flag stays up three clocks longer than the persistent flag
		if (free_now && st.free_cnt >= SSR_FREE_W_CNT) begin
			next_st.free_w   = 1'b1;
			next_st.hold_cnt = SSR_FREE_HOLD;
		end else if (st.hold_cnt != 3'h0_000) begin
			next_st.hold_cnt = st.hold_cnt - 3'h0_001;
		end else begin
			next_st.free_w = 1'b0;
		end
		// Bus handshake: accept address and data in any order; each
		// channel is held until both are in, then the write runs once
		// and the response blocks new writes until it is taken
		next_st.rx_pop  = 1'b0;
		next_st.tx_push = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_h = 1'b1;
			next_st.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_h = 1'b1;
			next_st.w_d = s_axi_wdata;
			next_st.w_s = s_axi_wstrb;
		end
		// A write runs once both halves are held
		do_wr = st.aw_h && st.w_h && !st.bvalid;
		do_rd = s_axi_arvalid && s_axi_arready;
		wb = st.w_d[7:0];
		// Reads that clear latched flags
		rd_xfer  = do_rd && s_axi_araddr == SSR_ADDR_XFER_STAT;
		rd_phase = do_rd && s_axi_araddr == SSR_ADDR_PHASE;
		// Write completes: decode and respond. Only byte lane 0 holds
		// a register; upper lanes are dropped without an error
		if (do_wr) begin
			next_st.aw_h   = 1'b0;
			next_st.w_h    = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = SSR_RESP_OK;
			unique case (st.aw_a)
				SSR_ADDR_PHASE: begin
					if (st.w_s[0]) next_st.tgt_id = wb;
				end
				SSR_ADDR_SEL_ID: begin
					if (st.w_s[0]) next_st.own_id = wb;
				end
				SSR_ADDR_DATA: begin
					if (st.w_s[0]) begin
						next_st.tx_byte = wb;
						next_st.tx_push = 1'b1;
					end
				end
				SSR_ADDR_IRQ_STAT: begin
					if (st.w_s[0]) next_st.ev = st.ev & ~wb[3:0];
				end
				SSR_ADDR_IRQ_MASK: begin
					if (st.w_s[0]) next_st.mask = wb[3:0];
				end
				SSR_ADDR_XFER_STAT: ;                       // Read-only, ignored
				default: next_st.bresp = SSR_RESP_ERR;      // Unmapped
			endcase
		end
		// Response stands until the master takes it
		if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
		// Read: answer one cycle after address taken. A read of the
		// byte port pops the buffer, so software that reads it twice
		// by mistake loses a received byte
		if (do_rd) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = SSR_RESP_OK;
			next_st.rdata  = 32'h0_000;
			unique case (s_axi_araddr)
				SSR_ADDR_XFER_STAT: next_st.rdata[7:0] = xfer_stat;
				SSR_ADDR_PHASE:     next_st.rdata[7:0] = phase_stat;
				SSR_ADDR_SEL_ID:    next_st.rdata[7:0] = st.sel_id;
				SSR_ADDR_DATA: begin
					next_st.rdata[7:0] = rx_byte;
					next_st.rx_pop     = 1'b1;
				end
				SSR_ADDR_IRQ_STAT:  next_st.rdata[3:0] = st.ev;
				SSR_ADDR_IRQ_MASK:  next_st.rdata[3:0] = st.mask;
				default: next_st.rresp = SSR_RESP_ERR;
			endcase
		end
		// Read answer stands until taken
		if (st.rvalid && s_axi_rready) next_st.rvalid = 1'b0;
		// Latched flags: clearing read first, then sets win. A flag
		// that sets in the very cycle of its clearing read is thus
		// kept for the next read instead of being lost
		if (rd_xfer) begin
			next_st.sys_parity_err = 1'b0;
		end
		if (rd_phase) begin
			next_st.halted = 1'b0;
			next_st.bfpd   = 1'b0;
		end
		if (sys_par_even) next_st.sys_parity_err = 1'b1;
		// Halt only as initiator: request edge at count zero, or a
		// data parity error
		if (!target_mode && ((st.rq[1] && !st.rq_d && count_zero) ||
				scsi_par_err)) begin
			next_st.halted = 1'b1;
		end
		if (bus_free_phase) next_st.bfpd = 1'b1;
		// Completion levels track the byte counter end count; they
		// fall as soon as the core drops end count for a new transfer
		if (!end_count) begin
			next_st.td      = 1'b0;
			next_st.cmpl_in = 1'b0;
		end else begin
			if (last_out) next_st.td = 1'b1;
			if (last_in && target_mode && !phase_stat[0]) begin
				next_st.cmpl_in = 1'b1;
			end
		end
		// Selector id with own bit masked, using the own id that
		// stands at the moment of the strobe
		if (sel_id_stb) next_st.sel_id = sel_id_bus & ~st.own_id;
		// Sticky events, set wins over write-one clear; completion
		// fires on the rising edge of the bus complete level or on last out at end count
		if (bus_xfer_complete && !st.stc_d) next_st.ev[SSR_E_CMPL] = 1'b1;
		if (last_out && end_count) next_st.ev[SSR_E_CMPL] = 1'b1;
		if (sys_par_even) next_st.ev[SSR_E_SYS_PARITY_ERR] = 1'b1;
		if (next_st.halted && !st.halted) next_st.ev[SSR_E_HALT] = 1'b1;
		if (bus_free_phase) next_st.ev[SSR_E_BFPD] = 1'b1;
		// A set mask bit keeps its event off the interrupt line
		next_st.irq = |(next_st.ev & ~next_st.mask);
		// Readies from the next state: low while a channel is held,
		// while a write response waits or a read answer stands
		next_st.awrdy = !next_st.aw_h && !next_st.bvalid;
		next_st.wrdy  = !next_st.w_h && !next_st.bvalid;
		next_st.arrdy = !next_st.rvalid;
	end

	// State register with synchronous reset. Reset clears every
	// flag, id and counter; only the channel readies come up high,
	// so a master may start on the first edge after release
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st       <= '0;
			st.awrdy <= 1'b1;
			st.wrdy  <= 1'b1;
			st.arrdy <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
endmodule

// >>> design/ssr_pkg.sv
// Package: offsets, field positions, reset values and counts of the status/id block
package ssr_pkg;
	// Register indices as printed, then byte addresses (each byte address is four times the printed offset)
	localparam logic [3:0] SSR_IDX_XFER_STAT = 4'h0_00C; // Transfer/parity status
	localparam logic [3:0] SSR_IDX_PHASE     = 4'h0_00D; // Phase/condition, target id
	localparam logic [3:0] SSR_IDX_SEL_ID    = 4'h0_00E; // Selector id, own id
	localparam logic [3:0] SSR_IDX_DATA      = 4'h0_00F; // Byte port
	localparam logic [3:0] SSR_IDX_IRQ_STAT  = 4'h0_000; // Sticky event status
	localparam logic [3:0] SSR_IDX_IRQ_MASK  = 4'h0_001; // Event mask
	localparam logic [7:0] SSR_ADDR_XFER_STAT = 8'h0_030;
	localparam logic [7:0] SSR_ADDR_PHASE     = 8'h0_034;
	localparam logic [7:0] SSR_ADDR_SEL_ID    = 8'h0_038;
	localparam logic [7:0] SSR_ADDR_DATA      = 8'h0_03C;
	localparam logic [7:0] SSR_ADDR_IRQ_STAT  = 8'h0_000;
	localparam logic [7:0] SSR_ADDR_IRQ_MASK  = 8'h0_004;
	// Transfer/parity status bit positions
	localparam int SSR_B_STC  = 3;
	localparam int SSR_B_TD   = 4;
	localparam int SSR_B_SYS_PARITY_ERR = 5;
	localparam int SSR_B_RST  = 6;
	localparam int SSR_B_ATN  = 7;
	// Phase/condition bit positions
	localparam int SSR_B_FREE_P = 3;
	localparam int SSR_B_FREE_W = 4;
	localparam int SSR_B_HALT   = 5;
	localparam int SSR_B_BFPD   = 6;
	// Interrupt event bit positions
	localparam int SSR_E_CMPL = 0;
	localparam int SSR_E_SYS_PARITY_ERR = 1;
	localparam int SSR_E_HALT = 2;
	localparam int SSR_E_BFPD = 3;
	// Bus-free timing in internal clocks
	localparam logic [2:0] SSR_FREE_P_CNT = 3'h0_004;
	localparam logic [2:0] SSR_FREE_W_CNT = 3'h0_005;
	localparam logic [2:0] SSR_FREE_HOLD  = 3'h0_003;
	// Reset values
	localparam logic [7:0] SSR_RST_BYTE = 8'h0_000;
	localparam logic [3:0] SSR_RST_EV   = 4'h0_000;
	// Bus responses
	localparam logic [1:0] SSR_RESP_OK  = 2'h0_000;
	localparam logic [1:0] SSR_RESP_ERR = 2'h0_002;
endpackage

// >>> tb/ssr_scsi_dev.sv
// Far-side SCSI device model that owns the bus control lines
`timescale 1ns/1ns
module ssr_scsi_dev (
	input  wire logic       mclk,  // Clock
	input  wire logic [7:0] want,  // Wanted levels
	output logic      [7:0] lines  // bsy sel rst atn msg cd io req
);
	// Levels move just after an edge, as a synchronous owner would
	always_ff @(posedge mclk) begin
		lines <= want;
	end
endmodule

// >>> tb/ssr_assertions.sv
// Checker for the status, id and byte-port register block
`timescale 1ns/1ns
module ssr_assertions
	import ssr_pkg::*;
(
	input wire logic        mclk, reset_n,              // Clock, reset
	input wire logic [7:0]  s_axi_awaddr, s_axi_araddr, // Addresses
	input wire logic [31:0] s_axi_wdata, s_axi_rdata,   // Data
	input wire logic        s_axi_awvalid, s_axi_wvalid, // Write valids
	input wire logic        s_axi_bvalid, s_axi_rvalid, // Answers
	input wire logic        s_axi_arvalid, s_axi_arready, // Read address
	input wire logic        scsi_bsy, scsi_sel, scsi_rst, // Bus lines
	input wire logic        scsi_atn, scsi_msg, scsi_cd, scsi_io, // Lines
	input wire logic [7:0]  rx_byte, tx_byte,           // Byte port
	input wire logic        rx_pop, tx_push,            // Port strobes
	input wire logic [7:0]  target_id_select, own_bus_id // Stored ids
);
	logic [7:0] wa, wd; // Last write address and data
	logic [4:0] lv;     // Line levels one edge ago
	logic [2:0] qc;     // Edges the lines held still
	logic [3:0] fc, bc; // Free and busy run lengths
	wire ar = s_axi_arvalid && s_axi_arready; // Read address taken
	wire fr = !scsi_bsy && !scsi_sel;         // Bus free at the pins
	wire [4:0] ln = {scsi_rst, scsi_atn, scsi_msg, scsi_cd, scsi_io};
	wire [7:0] rb = s_axi_rdata[7:0];         // Read byte
	// Lines must be quiet long enough to pass the two-flop sync
	wire q30 = ar && qc > 3'h3 && s_axi_araddr == SSR_ADDR_XFER_STAT;
	wire q34 = ar && qc > 3'h3 && s_axi_araddr == SSR_ADDR_PHASE;
	// Counters saturate, so long waits never wrap
	always_ff @(posedge mclk) begin
		lv <= ln;
		if (s_axi_awvalid) wa <= s_axi_awaddr;
		if (s_axi_wvalid) wd <= s_axi_wdata[7:0];
		if (!reset_n || lv != ln) qc <= 3'h0;
		else if (qc != 3'h7) qc <= qc + 3'h1;
		if (!reset_n || !fr) fc <= 4'h0;
		else if (fc != 4'hF) fc <= fc + 4'h1;
		if (!reset_n || fr) bc <= 4'h0;
		else if (bc != 4'hF) bc <= bc + 4'h1;
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!reset_n);
	AST_RST_LIVE: assert property (q30 |=> rb[SSR_B_RST] == $past(scsi_rst))
		else $error("reset bit off the line");
	AST_ATN_LIVE: assert property (q30 |=> rb[SSR_B_ATN] == $past(scsi_atn))
		else $error("attention bit off the line");
	AST_PHASE: assert property (q34 |=> rb[2:0] == $past(ln[2:0]))
		else $error("phase bits off the lines");
	AST_FREE_ON: assert property (q34 && fc > 4'hB |=> rb[4:3] == 2'h3)
		else $error("free bits low on a free bus");
	AST_FREE_OFF: assert property (q34 && bc > 4'h9 |=> rb[4:3] == 2'h0)
		else $error("free bits high on a busy bus");
	AST_TGT_ID:
		assert property ($rose(s_axi_bvalid) && wa == SSR_ADDR_PHASE
			|-> target_id_select == wd) else $error("target id not stored");
	AST_OWN_ID:
		assert property ($rose(s_axi_bvalid) && wa == SSR_ADDR_SEL_ID
			|-> own_bus_id == wd) else $error("own id not stored");
	AST_TX_PUSH:
		assert property ($rose(s_axi_bvalid) && wa == SSR_ADDR_DATA
			|-> ##[0:1] tx_push && tx_byte == wd) else $error("byte not pushed");
	AST_RX_POP:
		assert property (ar && s_axi_araddr == SSR_ADDR_DATA |=> s_axi_rvalid
			&& rx_pop && rb == $past(rx_byte)) else $error("byte not popped");
	cover property (q34 && fc == 4'hF);
	cover property (q34 && bc > 4'h9);
	cover property ($rose(s_axi_bvalid) && wa == SSR_ADDR_DATA);
endmodule
bind ssr_regs ssr_assertions u_ssr_assertions (.*);

// >>> tb/tb_top.sv
// Self-checking bench for the status, id and byte-port register block
`timescale 1ns/1ns
module tb_top;
	import ssr_pkg::*;
	logic        mclk = 1'h0, reset_n = 1'h0; // Clock, reset
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // Addresses
	logic [31:0] s_axi_wdata = 32'h0000_0000;  // Write data
	logic [3:0]  s_axi_wstrb = 4'h1;  // Only lane 0 holds a register
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0; // Write valids
	logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h0; // Handshakes
	logic        s_axi_rready = 1'h0;
	logic        target_mode = 1'h0, end_count = 1'h0, count_zero = 1'h0;
	logic [7:0]  sel_id_bus = 8'h00, rx_byte = 8'h00, want = 8'h00;
	logic [5:0]  ev = 6'h00;          // One bit per event pulse
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, rx_pop, tx_push, irq, ia; // Strobes, irq
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr; // Responses
	logic [31:0] s_axi_rdata, rv;              // Read data, last read
	logic [7:0]  tx_byte, target_id_select, own_bus_id, lines;
	wire logic   scsi_bsy, scsi_sel, scsi_rst, scsi_atn, scsi_msg, scsi_cd;
	wire logic   scsi_io, incoming_request_line, last_in, last_out;
	wire logic   sys_par_even, scsi_par_err, bus_free_phase, sel_id_stb;
	int          error_cnt = 0, check_count = 0; // Mismatches, checks
	logic [9:0]  row [8] = '{10'h000, 10'h0C5, 10'h12A, 10'h1EF,
		10'h210, 10'h2D5, 10'h33A, 10'h3FF}; // Phase, rst, atn, expected
	assign {scsi_bsy, scsi_sel, scsi_rst, scsi_atn, scsi_msg, scsi_cd,
		scsi_io, incoming_request_line} = lines;
	assign {sel_id_stb, bus_free_phase, scsi_par_err, sys_par_even,
		last_out, last_in} = ev;
	ssr_regs u_ssr_regs (.*);
	ssr_scsi_dev u_ssr_scsi_dev (.mclk(mclk), .want(want), .lines(lines));
	always #5 mclk = ~mclk;
	// Compare one value, counting it
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	// One bus cycle; readiness is sampled at the falling edge, which
	// holds what the next rising edge sees, so no race with the slave
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, tr, dn;
		int k = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		do begin
			@(negedge mclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_arvalid && s_axi_arready;
			dn = w ? s_axi_bvalid : s_axi_rvalid;
			rv = s_axi_rdata;
			rr = w ? s_axi_bresp : s_axi_rresp;
			@(posedge mclk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tr) s_axi_arvalid <= 1'h0;
			k++;
		end while (!dn && k < 40);
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		if (!dn) begin
			error_cnt++;
			$display("wrong value at %0t: bus answer missing", $time);
		end
	endtask
	// Read and compare the masked bits
	task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
		bus(1'h0, a, 8'h00);
		chk(rv & m, e);
	endtask
	// Single-cycle event pulse
	task automatic pls(input int i);
		@(posedge mclk);
		ev[i] <= 1'h1;
		@(posedge mclk);
		ev[i] <= 1'h0;
	endtask
	// Set bus lines, then let them pass the sync
	task automatic ln(input logic [7:0] v);
		@(posedge mclk);
		want <= v;
		repeat (7) @(posedge mclk);
	endtask
	task automatic tdone(input string s);
		$display("test %s ended, %0d wrong", s, error_cnt);
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		error_cnt++;
		close_out();
	end
	// Main sequence: table rows first, then hand-written cases
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'h1;
		@(negedge mclk);
		chk(32'({target_id_select, own_bus_id, irq}), 32'h0);
		foreach (row[i]) begin
			ln({2'h0, row[i][6:5], row[i][9:7], 1'h0});
			rc(SSR_ADDR_PHASE, 32'h7, 32'(row[i][4:2]));
			rc(SSR_ADDR_XFER_STAT, 32'hC0, 32'({row[i][1:0], 6'h00}));
		end
		tdone("phase rows");
		ln(8'h80);
		repeat (4) @(posedge mclk);
		rc(SSR_ADDR_PHASE, 32'h18, 32'h00);
		ln(8'h00);
		repeat (6) @(posedge mclk);
		rc(SSR_ADDR_PHASE, 32'h18, 32'h18);
		bus(1'h1, SSR_ADDR_PHASE, 8'hA5);
		chk(32'(target_id_select), 32'hA5);
		bus(1'h1, SSR_ADDR_SEL_ID, 8'h24);
		chk(32'(own_bus_id), 32'h24);
		sel_id_bus <= 8'h26;
		pls(5);
		rc(SSR_ADDR_SEL_ID, 32'hFF, 32'h02);
		rx_byte <= 8'h5A;
		rc(SSR_ADDR_DATA, 32'hFF, 32'h5A);
		bus(1'h1, SSR_ADDR_DATA, 8'hC3);
		chk(32'(tx_byte), 32'hC3);
		tdone("ids and byte port");
		end_count <= 1'h1;
		pls(1);
		rc(SSR_ADDR_XFER_STAT, 32'h18, 32'h18);
		end_count <= 1'h0;
		target_mode <= 1'h1;
		@(posedge mclk);
		end_count <= 1'h1;
		pls(0);
		rc(SSR_ADDR_XFER_STAT, 32'h18, 32'h08);
		end_count <= 1'h0;
		ln(8'h02);
		end_count <= 1'h1;
		pls(0);
		rc(SSR_ADDR_XFER_STAT, 32'h18, 32'h00);
		pls(1);
		rc(SSR_ADDR_XFER_STAT, 32'h18, 32'h18);
		end_count <= 1'h0;
		pls(2);
		rc(SSR_ADDR_XFER_STAT, 32'h20, 32'h20);
		rc(SSR_ADDR_XFER_STAT, 32'h20, 32'h00);
		fork
			pls(2);
			bus(1'h0, SSR_ADDR_XFER_STAT, 8'h00);
		join
		rc(SSR_ADDR_XFER_STAT, 32'h20, 32'h20);
		tdone("transfer and parity");
		pls(3);
		rc(SSR_ADDR_PHASE, 32'h20, 32'h00);
		target_mode <= 1'h0;
		count_zero <= 1'h1;
		ln(8'h01);
		pls(4);
		rc(SSR_ADDR_PHASE, 32'h60, 32'h60);
		rc(SSR_ADDR_PHASE, 32'h60, 32'h00);
		pls(3);
		rc(SSR_ADDR_PHASE, 32'h20, 32'h20);
		tdone("halt and bus free");
		// A set mask bit blocks its event; pending events remain
		bus(1'h1, SSR_ADDR_IRQ_MASK, 8'h0F);
		repeat (2) @(negedge mclk);
		ia = irq;
		chk(32'(ia), 32'h0);
		bus(1'h1, SSR_ADDR_IRQ_MASK, 8'h00);
		repeat (2) @(negedge mclk);
		chk(32'(irq), 32'h1);
		rc(SSR_ADDR_IRQ_STAT, 32'h2, 32'h2);
		bus(1'h1, SSR_ADDR_IRQ_STAT, 8'h0F);
		rc(SSR_ADDR_IRQ_STAT, 32'hF, 32'h0);
		chk(32'(irq), 32'h0);
		bus(1'h0, 8'h10, 8'h00);
		chk(32'(rr), 32'(SSR_RESP_ERR));
		bus(1'h1, SSR_ADDR_XFER_STAT, 8'hFF);
		chk(32'(rr), 32'(SSR_RESP_OK));
		tdone("interrupt and map");
		// Reset in mid-run clears ids, flags and the interrupt
		pls(2);
		repeat (2) @(negedge mclk);
		chk(32'({irq, target_id_select}), 32'h1A5);
		@(posedge mclk);
		reset_n <= 1'h0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'h1;
		@(negedge mclk);
		chk(32'({irq, target_id_select, own_bus_id}), 32'h0);
		rc(SSR_ADDR_XFER_STAT, 32'h20, 32'h00);
		tdone("reset in mid-run");
		close_out();
	end
endmodule
